// ---- rtl/adc_conversion_control.sv ----
// Function
// (R1) bit 7 powers the converter up or down
// (R2) bit 6 selects external reference
// (R3) divide code sets converter clock ratio
// (R4) software keeps converter clock within limit
// (R5) conversion phase lasts seventeen converter clocks
// (R6) bits 3:2 set acquisition of 1-4 clocks
// (R7) software should choose three or more clocks
// (R8) bit 1 lets timer overflow trigger
// (R9) bit 0 lets low pin pulse trigger
// (R10) register resets zero, byte access only
// (R11) pin synchronised, falling edge, ignored while busy
// (R12) conversion is acquisition then conversion phase
`default_nettype none
module adc_conversion_control
    import adc_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,     // special function address
    input wire logic sfr_wr_i,             // byte write strobe
    input wire logic [7:0] sfr_wdata_i,    // write data
    output logic [7:0] sfr_rdata_o,        // read data, zero when not addressed
    input wire logic timer_overflow_i,     // one-cycle pulse, same clock
    input wire logic convert_start_pin_n_i, // external pin, active low
    output logic converter_power_on_o,
    output logic ref_source_select_o,
    output logic conv_clk_tick_o,          // one-cycle converter clock tick
    output logic track_o,                  // acquisition under way
    output logic busy_o,                   // conversion in progress
    output logic result_ready_o            // one-cycle pulse at end
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] cfg;          // the control byte
        logic [2:0] pin_sync;     // three-stage synchroniser
        logic pin_level;          // agreed pin level
        conv_state_t state;
        logic [4:0] cnt;          // converter clocks left in phase
        logic done;
    } ctl_st_t;
    ctl_st_t st_r;
    ctl_st_t st_nxt;
    logic tick;
    logic pin_fall;
    logic trigger;

    ////////////////////////////////////////////////////////////////////
    // address decode, shared by write, readback and checks
    function automatic logic is_cfg_addr(input logic [7:0] addr);
        // the byte has one home; every other address misses
        return addr == ADC_CONFIG_CONTROL_ADDR;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // converter clock
    conv_clk_divider u_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .run_i(st_r.cfg[POWER_ON_BIT]),
        .div_sel_i(st_r.cfg[DIV_HI_BIT:DIV_LO_BIT]),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // trigger decode
    always_comb begin
        // (R11) edge on agreed stages
        pin_fall = st_r.pin_level && (st_r.pin_sync[2:1] == 2'b00);
        // (R8) timer trigger gated
        // (R9) pin trigger gated
        trigger = st_r.cfg[POWER_ON_BIT] &&
                  ((st_r.cfg[TIMER_TRIG_BIT] && timer_overflow_i) ||
                   (st_r.cfg[PIN_TRIG_BIT] && pin_fall));
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        // (R10) whole byte write only
        if (sfr_wr_i && is_cfg_addr(sfr_addr_i)) begin
            st_nxt.cfg = sfr_wdata_i;
        end
        // first stage only feeds the second
        st_nxt.pin_sync = {st_r.pin_sync[1:0], convert_start_pin_n_i};
        if (st_r.pin_sync[2] == st_r.pin_sync[1]) begin
            st_nxt.pin_level = st_r.pin_sync[2];
        end
        unique case (st_r.state)
            ST_IDLE: begin
                // (R11) triggers only taken when idle
                if (trigger) begin
                    st_nxt.state = ST_ACQ;
                    // (R6) acquisition length from code
                    st_nxt.cnt = {3'b000, st_r.cfg[ACQ_HI_BIT:ACQ_LO_BIT]} + 5'h01;
                end
            end
            ST_ACQ: begin
                // (R12) acquisition precedes conversion
                if (tick) begin
                    if (st_r.cnt == 5'h01) begin
                        st_nxt.state = ST_CONV;
                        // (R5) seventeen clock conversion
                        st_nxt.cnt = CONV_CLOCKS;
                    end else begin
                        st_nxt.cnt = st_r.cnt - 5'h01;
                    end
                end
            end
            ST_CONV: begin
                if (tick) begin
                    if (st_r.cnt == 5'h01) begin
                        st_nxt.state = ST_IDLE;
                        st_nxt.cnt = 5'h00;
                        st_nxt.done = 1'b1;
                    end else begin
                        st_nxt.cnt = st_r.cnt - 5'h01;
                    end
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
        // (R1) power down aborts any conversion
        if (!st_r.cfg[POWER_ON_BIT]) begin
            st_nxt.state = ST_IDLE;
            st_nxt.cnt = 5'h00;
            st_nxt.done = 1'b0;
        end
    end

    // registers; pin idles high so the synchroniser resets high
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.cfg <= ADC_CONFIG_CONTROL_RESET;
            st_r.pin_sync <= 3'b111;
            st_r.pin_level <= 1'b1;
            st_r.state <= ST_IDLE;
            st_r.cnt <= 5'h00;
            st_r.done <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    // (R10) readback of the byte
    assign sfr_rdata_o = is_cfg_addr(sfr_addr_i) ? st_r.cfg : 8'h00;
    // (R1) power output
    assign converter_power_on_o = st_r.cfg[POWER_ON_BIT];
    // (R2) reference select output
    assign ref_source_select_o = st_r.cfg[REF_SEL_BIT];
    assign conv_clk_tick_o = tick;
    assign track_o = (st_r.state == ST_ACQ);
    assign busy_o = (st_r.state != ST_IDLE);
    assign result_ready_o = st_r.done;

    ////////////////////////////////////////////////////////////////////
    // checks
    // software, not hardware, keeps the converter clock slow enough;
    // nothing here refuses a fast ratio
    // (R10) reset clears byte
    AST_RESET_ZERO: assert property (@(posedge ref_clk_i) // (R10)
        $fell(rst_i) |-> st_r.cfg == ADC_CONFIG_CONTROL_RESET)
        else $error("config not zero after reset");
    // (R10) byte write lands
    AST_WRITE_STORES: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R10)
        sfr_wr_i && is_cfg_addr(sfr_addr_i) |=> sfr_rdata_o == $past(sfr_wdata_i) || !is_cfg_addr(sfr_addr_i))
        else $error("byte write not stored");
    // (R10) other addresses read zero
    AST_OTHER_ADDR_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R10)
        !is_cfg_addr(sfr_addr_i) |-> sfr_rdata_o == 8'h00)
        else $error("unaddressed read not zero");
    // (R1) power follows write
    AST_POWER_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R1)
        sfr_wr_i && is_cfg_addr(sfr_addr_i) |=> converter_power_on_o == $past(sfr_wdata_i[POWER_ON_BIT]))
        else $error("power bit not taken from write");
    // (R1) powered down stays quiet
    AST_POWER_OFF_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R1)
        !converter_power_on_o |=> !busy_o && !tick)
        else $error("activity while powered down");
    // (R2) reference follows write
    AST_REF_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R2)
        sfr_wr_i && is_cfg_addr(sfr_addr_i) |=> ref_source_select_o == $past(sfr_wdata_i[REF_SEL_BIT]))
        else $error("reference select mismatch");
    // (R3) divide-by-eight spacing; a write mid-period aborts the attempt
    AST_DIV8_PERIOD: assert property (@(posedge ref_clk_i) disable iff (rst_i || sfr_wr_i) // (R3)
        tick && st_r.cfg[DIV_HI_BIT:DIV_LO_BIT] == 2'b00 && $stable(st_r.cfg) |=> !tick [*7] ##1 tick)
        else $error("divide by eight period wrong");
    // (R8) overflow starts acquisition
    AST_TIMER_TRIG: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R8)
        !busy_o && converter_power_on_o && st_r.cfg[TIMER_TRIG_BIT] && timer_overflow_i |=> track_o)
        else $error("timer overflow did not start");
    // (R9) no enabled trigger, no start
    AST_NO_TRIG: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R9)
        !busy_o && !(st_r.cfg[TIMER_TRIG_BIT] && timer_overflow_i) &&
        !(st_r.cfg[PIN_TRIG_BIT] && pin_fall) |=> !busy_o)
        else $error("conversion without enabled trigger");
    // (R11) pin fall starts acquisition
    AST_PIN_TRIG: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R11)
        !busy_o && converter_power_on_o && st_r.cfg[PIN_TRIG_BIT] && pin_fall |=> track_o)
        else $error("pin edge did not start");
    // (R11) one fall, one event
    AST_PIN_ONE_EVENT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R11)
        pin_fall |=> !pin_fall)
        else $error("pin fall seen twice");
    // (R11) busy ignores triggers
    AST_BUSY_HOLDS: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R11)
        busy_o && converter_power_on_o && !(tick && st_r.cnt == 5'h01 && !track_o) |=> busy_o)
        else $error("busy dropped early");
    // (R5) conversion starts at seventeen
    AST_ACQ_TO_CONV: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R5)
        track_o ##1 !track_o && busy_o |-> st_r.cnt == CONV_CLOCKS)
        else $error("conversion phase not seventeen");
    // (R6) acquisition count from code in force at the trigger
    AST_ACQ_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R6)
        $rose(track_o) |-> st_r.cnt == {3'b000, $past(st_r.cfg[ACQ_HI_BIT:ACQ_LO_BIT])} + 5'h01)
        else $error("acquisition length wrong");
    // (R12) last acquisition tick hands over
    AST_ACQ_END: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R12)
        track_o && tick && st_r.cnt == 5'h01 && converter_power_on_o |=> busy_o && !track_o)
        else $error("acquisition did not hand over");
    // (R5) last conversion tick ends
    AST_CONV_END: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R5)
        busy_o && !track_o && tick && st_r.cnt == 5'h01 && converter_power_on_o
        |=> result_ready_o && !busy_o)
        else $error("conversion did not finish on count");
    // (R12) result only after conversion
    AST_DONE_AFTER_CONV: assert property (@(posedge ref_clk_i) disable iff (rst_i) // (R12)
        result_ready_o |-> $past(st_r.state) == ST_CONV && !busy_o)
        else $error("result without conversion");
    COV_TIMER: cover property (@(posedge ref_clk_i) st_r.cfg[TIMER_TRIG_BIT] && timer_overflow_i && !busy_o);
    COV_PIN: cover property (@(posedge ref_clk_i) st_r.cfg[PIN_TRIG_BIT] && pin_fall && !busy_o);
    COV_DONE: cover property (@(posedge ref_clk_i) result_ready_o);
    COV_BUSY_EDGE: cover property (@(posedge ref_clk_i) busy_o && pin_fall);
    COV_LONG_ACQ: cover property (@(posedge ref_clk_i) $rose(track_o) && st_r.cfg[ACQ_HI_BIT:ACQ_LO_BIT] == 2'b11);
endmodule
`default_nettype wire

// ---- rtl/adc_ctl_pkg.sv ----
`default_nettype none
package adc_ctl_pkg;
    // register address in the special function space
    localparam logic [7:0] ADC_CONFIG_CONTROL_ADDR = 8'hEF;
    localparam logic [7:0] ADC_CONFIG_CONTROL_RESET = 8'h00;
    // field positions
    localparam int POWER_ON_BIT = 7;
    localparam int REF_SEL_BIT = 6;
    localparam int DIV_HI_BIT = 5;
    localparam int DIV_LO_BIT = 4;
    localparam int ACQ_HI_BIT = 3;
    localparam int ACQ_LO_BIT = 2;
    localparam int TIMER_TRIG_BIT = 1;
    localparam int PIN_TRIG_BIT = 0;
    // divider ratios per code
    localparam logic [5:0] DIV_CODE0 = 6'h08;
    localparam logic [5:0] DIV_CODE1 = 6'h04;
    localparam logic [5:0] DIV_CODE2 = 6'h10;
    localparam logic [5:0] DIV_CODE3 = 6'h20;
    // conversion phase length in converter clocks
    localparam logic [4:0] CONV_CLOCKS = 5'h11;
    // master clock period for timing figures
    localparam int MCLK_PERIOD_NS = 50;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;
endpackage
`default_nettype wire

// ---- rtl/conv_clk_divider.sv ----
`default_nettype none
// makes a one-cycle converter clock tick every ratio master clocks
module conv_clk_divider
    import adc_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] div_sel_i,
    output logic tick_o
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } div_st_t;
    div_st_t st_r;
    div_st_t st_nxt;
    logic [5:0] ratio;

    // ratio decode
    // (R3) code to divide ratio
    always_comb begin
        unique case (div_sel_i)
            2'b00: ratio = DIV_CODE0;
            2'b01: ratio = DIV_CODE1;
            2'b10: ratio = DIV_CODE2;
            2'b11: ratio = DIV_CODE3;
        endcase
    end

    // free counter, held in reset while powered down
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run_i) begin
            st_nxt.cnt = 6'h00;
        end else if (st_r.cnt >= ratio - 6'h01) begin
            st_nxt.cnt = 6'h00;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule
`default_nettype wire

// ---- test/conv_start_source.sv ----
`default_nettype none
// outside world: convert-start pin source and timer overflow
module conv_start_source (
    input wire logic ref_clk_i,
    output var logic convert_start_pin_n_o,
    output var logic timer_overflow_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin idles high as if pulled up
    initial begin
        convert_start_pin_n_o = 1'b1;
        timer_overflow_o = 1'b0;
    end
    // active low pulse
    // four clocks low, comfortably over the minimum width
    task automatic pin_pulse();
        @(negedge ref_clk_i);
        convert_start_pin_n_o = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        convert_start_pin_n_o = 1'b1;
    endtask
    // one-cycle overflow in the block's own clock
    task automatic timer_pulse();
        @(negedge ref_clk_i);
        timer_overflow_o = 1'b1;
        @(negedge ref_clk_i);
        timer_overflow_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- test/test_adc_conversion_control.sv ----
`default_nettype none
module test_adc_conversion_control import adc_ctl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0; // clock, reset, strobe
    logic [7:0] addr = 8'hEF, wdata = 8'h00, rdata; // register access
    logic ovf, pin_n, pwr, ref_sel, tick, track, busy, rr; // block pins
    int failures = 0, comparisons = 0;
    logic [7:0] n_trk, n_busy, n_rr, gap; // observed counts
    logic [7:0] div_tab [4] = '{8'h08, 8'h04, 8'h10, 8'h20};
    always #25 ref_clk = ~ref_clk;
    adc_conversion_control adc_conversion_control_i (.ref_clk_i(ref_clk), .rst_i(rst),
        .sfr_addr_i(addr), .sfr_wr_i(wr_en), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .timer_overflow_i(ovf), .convert_start_pin_n_i(pin_n), .converter_power_on_o(pwr),
        .ref_source_select_o(ref_sel), .conv_clk_tick_o(tick), .track_o(track),
        .busy_o(busy), .result_ready_o(rr));
    conv_start_source conv_start_source_i (.ref_clk_i(ref_clk),
        .convert_start_pin_n_o(pin_n), .timer_overflow_o(ovf));
    ////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // strobe is one cycle wide, address parks on the register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge ref_clk);
        wr_en = 1'b0;
        addr = 8'hEF;
    endtask
    // read port is combinational, so look a little after the change
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        #1 d = rdata;
    endtask
    task automatic trig(input logic pin);
        if (pin) conv_start_source_i.pin_pulse();
        else conv_start_source_i.timer_pulse();
    endtask
    // fires one trigger, a second one while busy, and counts ticks
    task automatic watch(input logic pin, input int cycles);
        logic sent;
        sent = 1'b0;
        n_trk = 8'h00;
        n_busy = 8'h00;
        n_rr = 8'h00;
        fork trig(pin); join_none
        repeat (cycles) begin
            @(negedge ref_clk);
            if (tick === 1'b1 && track === 1'b1) n_trk++;
            if (tick === 1'b1 && busy === 1'b1) n_busy++;
            if (rr === 1'b1) n_rr++;
            if (!sent && n_busy == 2) begin
                sent = 1'b1;
                fork trig(pin); join_none
            end
        end
    endtask
    task automatic run(input logic [7:0] cfg, input logic pin, input logic [7:0] acq);
        wr(8'hEF, cfg);
        watch(pin, 1500);
        chk("acq ticks", n_trk, acq + 8'h01);
        chk("busy ticks", n_busy, acq + 8'h12);
        chk("result pulses", n_rr, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog sized well past the whole sequence
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rd(ADC_CONFIG_CONTROL_ADDR, gap);
        chk("cfg after reset", gap, ADC_CONFIG_CONTROL_RESET);
        wr(8'hEF, 8'hC0);
        chk("power", {7'h00, pwr}, 8'h01);
        chk("ref_source_select", {7'h00, ref_sel}, 8'h01);
        wr(8'hEE, 8'hFF);
        rd(8'hEF, gap);
        chk("other addr ignored", gap, 8'hC0);
        rd(8'hEE, gap);
        chk("other addr reads zero", gap, 8'h00);
        wr(8'hEF, 8'h40);
        chk("power off", {7'h00, pwr}, 8'h00);
        chk("ref kept", {7'h00, ref_sel}, 8'h01);
        // tick spacing per code; ratio four only clocks, never converts
        for (int k = 0; k < 4; k++) begin
            wr(8'hEF, 8'h80 | 8'(k << 4));
            repeat (3) begin
                gap = 8'h00;
                do begin
                    @(negedge ref_clk);
                    gap++;
                end while (tick !== 1'b1 && gap < 64);
            end
            chk("tick gap", gap, div_tab[k]);
        end
        // from here on only ratios of eight and more run
        wr(8'hEF, 8'h80);
        chk("int ref", {7'h00, ref_sel}, 8'h00);
        watch(1'b0, 40);
        chk("no timer enable", n_busy, 8'h00);
        watch(1'b1, 40);
        chk("no enable", n_busy, 8'h00);
        wr(8'hEF, 8'h13);
        watch(1'b0, 40);
        chk("powered down", {7'h00, busy}, 8'h00);
        chk("powered down ticks", n_busy, 8'h00);
        watch(1'b1, 40);
        chk("powered down pin", {7'h00, busy}, 8'h00);
        // every acquisition code, ratios eight and sixteen
        for (int k = 0; k < 4; k++) run(8'h82 | 8'((k & 1) << 5) | 8'(k << 2), 1'b0, 8'(k));
        // pin run keeps the recommended long acquisition
        run(8'hAD, 1'b1, 8'h03);
        // clearing power mid-conversion abandons the result
        wr(8'hEF, 8'h82);
        watch(1'b0, 20);
        chk("busy", {7'h00, busy}, 8'h01);
        wr(8'hEF, 8'h02);
        watch(1'b0, 100);
        chk("abort result", n_rr, 8'h00);
        chk("abort idle", {7'h00, busy}, 8'h00);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rd(8'hEF, gap);
        chk("cfg after reset", gap, 8'h00);
        chk("power after reset", {7'h00, pwr}, 8'h00);
        wr(8'hEF, 8'hC0);
        rd(8'hEF, gap);
        chk("write after reset", gap, 8'hC0);
        close_out();
    end
endmodule
`default_nettype wire
